//--- logic/timer1_pwm_params.svh
// offsets, field positions, reset values and counts of the timer1 pwm block
`ifndef TIMER1_PWM_PARAMS_SVH
`define TIMER1_PWM_PARAMS_SVH
// ==========================================================================
// register offsets on the plain register port
`define OFS_DT_PRESCALE   8'h23
`define OFS_DT_A          8'h24
`define OFS_DT_B          8'h25
`define OFS_PLL           8'h27
`define OFS_TOP           8'h2d
`define OFS_CMP_A         8'h2e
`define OFS_COUNT         8'h2f
`define OFS_CTRL          8'h30
`define OFS_FLAGS         8'h38
`define OFS_MASK          8'h39
// ==========================================================================
// field positions
`define PLL_LOCK_BIT      0
`define PLL_EN_BIT        1
`define PLL_FAST_BIT      2
`define CTRL_PWM_BIT      7
`define CTRL_OEB_BIT      6
`define CTRL_MODE_HI      5
`define CTRL_MODE_LO      4
`define CTRL_CS_HI        3
`define CTRL_CS_LO        0
`define FLAG_MATCH_BIT    6
`define FLAG_TOP_BIT      2
`define DT_TRUE_HI        7
`define DT_TRUE_LO        4
`define DT_INV_HI         3
`define DT_INV_LO         0
// ==========================================================================
// reset values and counts
`define RST_BYTE          8'h00
`define RST_TOP           8'hff
`define RST_DT_PRESCALE   2'h0
`define RST_PLL_EN        1'b0
`define FLAG_DELAY        2
`endif

//--- logic/timer1_pwm_pkg.sv
// types shared by the timer1 pwm block
package timer1_pwm_pkg;
  // ========================================================================
  // output mode of channel a in pwm operation
  typedef enum logic [1:0] {
    OUT_OFF  = 2'h0,
    OUT_OFF1 = 2'h1,
    OUT_CLR  = 2'h2,
    OUT_SET  = 2'h3
  } out_mode_t;
  typedef logic [7:0] byte_t;
endpackage

//--- logic/dt_if.sv
// carrier between the pwm core and one dead-time generator
`timescale 1ns/1ps
interface dt_if;
  logic       pwm;       // pwm signal to split
  logic       dtTick;    // prescaled dead-time tick
  logic [3:0] trueDelay; // delay before true output rises
  logic [3:0] invDelay;  // delay before inverted output rises
  logic       outTrue;   // true output of the pair
  logic       outInv;    // complementary output of the pair
  modport gen (input pwm, dtTick, trueDelay, invDelay,
               output outTrue, outInv);
  modport src (output pwm, dtTick, trueDelay, invDelay,
               input outTrue, outInv);
endinterface

//--- logic/timer_clk_select.sv
// timer clock selection: stopped, fast ticks /1..8 or system clock /1..1024
`timescale 1ns/1ps
module timer_clk_select (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       fastTick,
  input  wire logic       fastClockEnable,
  input  wire logic [3:0] clockSelect,
  output logic            timerTick
);
  logic [9:0]  divCnt_q;  // source tick counter
  logic [9:0]  divCnt_d;
  logic [3:0]  shiftAmt;  // log2 of the division
  logic [10:0] fullDiv;
  logic [9:0]  divMask;
  logic        srcTick;
  // ========================================================================
  // source and division decode
  always_comb begin
    if (clockSelect <= 4'h4) begin
      // fast source; falls back to system clock while it is disabled
      shiftAmt = 4'(clockSelect - 4'h1);
      srcTick  = fastClockEnable ? fastTick : 1'b1;
    end else begin
      shiftAmt = 4'(clockSelect - 4'h5);
      srcTick  = 1'b1;
    end
    fullDiv   = 11'h1 << shiftAmt;
    divMask   = 10'(fullDiv - 11'h1);
    timerTick = (clockSelect != 4'h0) && srcTick &&
                ((divCnt_q & divMask) == divMask);
    divCnt_d  = divCnt_q;
    if ((clockSelect != 4'h0) && srcTick) begin
      divCnt_d = 10'(divCnt_q + 10'h1);
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= 10'h0;
    end else begin
      divCnt_q <= divCnt_d;
    end
  end
  // ========================================================================
  // checks
  a_stop_no_tick: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (clockSelect == 4'h0) |-> !timerTick)
    else $error("timer ticks while stopped");
endmodule

//--- logic/deadtime_gen.sv
// one dead-time generator: pwm signal to non-overlapping complementary pair
`timescale 1ns/1ps
module deadtime_gen #(
  parameter int DT_W = 4
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  dt_if.gen         dt
);
  if (DT_W != 4) begin : g_bad_width
    $error("dead-time counter must be four bits");
  end
  logic            prev_q;  // pwm seen last cycle
  logic [DT_W-1:0] cnt_q;   // dead-time down counter
  logic [DT_W-1:0] cnt_d;
  logic            outT_q;
  logic            outT_d;
  logic            outI_q;
  logic            outI_d;
  logic            edgeSeen;
  // ========================================================================
  // edge detect, down count and output gating
  always_comb begin
    edgeSeen = dt.pwm != prev_q;
    cnt_d    = cnt_q;
    if (edgeSeen) begin
      cnt_d = dt.pwm ? dt.trueDelay : dt.invDelay;
    end else if (cnt_q != '0 && dt.dtTick) begin
      cnt_d = cnt_q - DT_W'(1);
    end
    // both low until the zero comparator releases the rising side
    outT_d = dt.pwm && (cnt_d == '0);
    outI_d = !dt.pwm && (cnt_d == '0);
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      cnt_q  <= '0;
      outT_q <= 1'b0;
      outI_q <= 1'b0;
    end else begin
      prev_q <= dt.pwm;
      cnt_q  <= cnt_d;
      outT_q <= outT_d;
      outI_q <= outI_d;
    end
  end
  assign dt.outTrue = outT_q;
  assign dt.outInv  = outI_q;
  // ========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_pair_no_overlap: assert property (!(outT_q && outI_q))
    else $error("both outputs of the pair high");
  a_rise_load: assert property (
    (dt.pwm && !prev_q) |=> (cnt_q == $past(dt.trueDelay)))
    else $error("rise did not load true delay");
  a_rise_held: assert property (
    (dt.pwm && !prev_q && dt.trueDelay != '0) |=> !outT_q)
    else $error("true output rose inside dead time");
  a_zero_delay: assert property (
    (!dt.pwm && prev_q && dt.invDelay == '0) |=> outI_q)
    else $error("zero dead time delayed inverted output");
  c_dead_time: cover property (cnt_q != '0 && !outT_q && !outI_q);
endmodule

//--- logic/timer1_pwm_deadtime.sv
// timer1 pwm core with register port, pll status and two dead-time pairs
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "timer1_pwm_params.svh"
// Operation
// - pll register bits seven to three read zero
// - lock bit reads one while pll locked
// - legacy mode forces fast clock and pll on
// - counter and compare a form pwm generator
// - counter counts zero to top, then restarts
// - top match sets overflow flag after delay
// - mode codes decide clear or set output
// - compare writes held, latched at top while pwm on
// - compare read returns latest written value
// - compare zero or top gives static output
// - overflow flag at top, interrupt needs enables
// - period is top plus one ticks
// - two independent dead-time generators, one per output
// - dead-time prescale divides by one to eight
// - edge loads four-bit counter with field
// - rising output waits until counter zero
// - dead time zero to fifteen prescaled ticks
// - high nibble true delay, low nibble inverted
// - clock select stops or divides timer clock
// - compare a match sets flag after delay
module timer1_pwm_deadtime #(
  parameter int DATA_W = 8
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output logic      [7:0] regRdData,
  input  wire logic       fastTick,
  input  wire logic       pllLockedPin,
  input  wire logic       compatModePin,
  input  wire logic       globalIntEnable,
  input  wire logic       pwmSrcB,
  output logic            pllEnable,
  output logic            fastClockEnable,
  output logic            pwmOutA,
  output logic            pwmOutANeg,
  output logic            pwmOutAEn,
  output logic            pwmOutB,
  output logic            pwmOutBNeg,
  output logic            pwmOutBEn,
  output logic            irqTop,
  output logic            irqMatchA
);
  if (DATA_W != 8) begin : g_bad_width
    $error("timer data path must be eight bits");
  end
  // ========================================================================
  // declarations
  timer1_pwm_pkg::byte_t     ctrl_q;      // pwm on, b enable, mode, select
  timer1_pwm_pkg::byte_t     ctrl_d;
  timer1_pwm_pkg::byte_t     top_q;       // top value
  timer1_pwm_pkg::byte_t     top_d;
  timer1_pwm_pkg::byte_t     cmpHold_q;   // temporary compare location
  timer1_pwm_pkg::byte_t     cmpHold_d;
  timer1_pwm_pkg::byte_t     cmpAct_q;    // compare value in use
  timer1_pwm_pkg::byte_t     cmpAct_d;
  timer1_pwm_pkg::byte_t     cnt_q;       // counter value
  timer1_pwm_pkg::byte_t     cnt_d;
  timer1_pwm_pkg::byte_t     dtA_q;       // dead-time value a
  timer1_pwm_pkg::byte_t     dtA_d;
  timer1_pwm_pkg::byte_t     dtB_q;       // dead-time value b
  timer1_pwm_pkg::byte_t     dtB_d;
  logic [1:0]                dtPre_q;     // dead-time prescale code
  logic [1:0]                dtPre_d;
  logic                      pllEn_q;     // software pll enable
  logic                      pllEn_d;
  logic                      fastEn_q;    // software fast clock enable
  logic                      fastEn_d;
  logic [1:0]                mask_q;      // {match a, top} enables
  logic [1:0]                mask_d;
  logic                      flagTop_q;   // top reached flag
  logic                      flagTop_d;
  logic                      flagMatch_q; // match a flag
  logic                      flagMatch_d;
  logic                      topEvt_q;    // event stage for flag delay
  logic                      topEvt_d;
  logic                      matchEvt_q;
  logic                      matchEvt_d;
  logic                      outA_q;      // raw pwm signal a
  logic                      outA_d;
  logic [2:0]                dtCnt_q;     // dead-time prescaler
  logic [2:0]                dtCnt_d;
  timer1_pwm_pkg::byte_t     rdData_q;
  timer1_pwm_pkg::byte_t     rdData_d;
  logic                      lockMeta_q;  // pin synchronisers
  logic                      lockSync_q;
  logic                      compMeta_q;
  logic                      compSync_q;
  timer1_pwm_pkg::out_mode_t mode;
  timer1_pwm_pkg::byte_t     stepCnt;     // value the counter moves to
  logic                      pwmOn;
  logic                      timerTick;
  logic                      step;
  logic                      atTop;
  logic                      arriveMatch;
  logic                      cntWr;
  logic                      wrFlags;
  logic [3:0]                dtFull;
  logic [2:0]                dtMask;
  logic                      dtTick;
  logic                      pllEnEff;
  logic                      fastEnEff;
  dt_if                      dtChanA ();
  dt_if                      dtChanB ();
  // ========================================================================
  // pin synchronisers: the first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
      compMeta_q <= 1'b0;
      compSync_q <= 1'b0;
    end else begin
      lockMeta_q <= pllLockedPin;
      lockSync_q <= lockMeta_q;
      compMeta_q <= compatModePin;
      compSync_q <= compMeta_q;
    end
  end
  // legacy mode overrides what software holds
  assign pllEnEff        = pllEn_q | compSync_q;
  assign fastEnEff       = fastEn_q | compSync_q;
  assign pllEnable       = pllEnEff;
  assign fastClockEnable = fastEnEff;
  // ========================================================================
  // timer clock and dead-time prescaler
  timer_clk_select u_clk_sel (
    .ref_clk         (ref_clk),
    .rst_b           (rst_b),
    .fastTick        (fastTick),
    .fastClockEnable (fastEnEff),
    .clockSelect     (ctrl_q[`CTRL_CS_HI:`CTRL_CS_LO]),
    .timerTick       (timerTick)
  );
  always_comb begin
    dtFull  = 4'h1 << dtPre_q;
    dtMask  = 3'(dtFull - 4'h1);
    dtTick  = timerTick && ((dtCnt_q & dtMask) == dtMask);
    dtCnt_d = timerTick ? 3'(dtCnt_q + 3'h1) : dtCnt_q;
  end
  // ========================================================================
  // decode of the counting step
  assign mode    = timer1_pwm_pkg::out_mode_t'(
                     ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign pwmOn   = ctrl_q[`CTRL_PWM_BIT];
  assign step    = pwmOn && timerTick;
  assign atTop   = cnt_q == top_q;
  // wrap after top gives a period of top plus one ticks
  assign stepCnt = atTop ? 8'h00 : 8'(cnt_q + 8'h01);
  assign arriveMatch = step && (stepCnt == cmpAct_q);
  assign cntWr   = regWrStb && (regAddr == `OFS_COUNT);
  assign wrFlags = regWrStb && (regAddr == `OFS_FLAGS);
  // ========================================================================
  // register writes, counter and compare buffering
  always_comb begin
    ctrl_d    = ctrl_q;
    top_d     = top_q;
    cmpHold_d = cmpHold_q;
    dtA_d     = dtA_q;
    dtB_d     = dtB_q;
    dtPre_d   = dtPre_q;
    pllEn_d   = pllEn_q;
    fastEn_d  = fastEn_q;
    mask_d    = mask_q;
    if (regWrStb) begin
      unique case (regAddr)
        `OFS_CTRL:        ctrl_d    = regWrData;
        `OFS_TOP:         top_d     = regWrData;
        `OFS_CMP_A:       cmpHold_d = regWrData;
        `OFS_DT_A:        dtA_d     = regWrData;
        `OFS_DT_B:        dtB_d     = regWrData;
        `OFS_DT_PRESCALE: dtPre_d   = regWrData[1:0];
        `OFS_PLL: begin
          pllEn_d  = regWrData[`PLL_EN_BIT];
          fastEn_d = regWrData[`PLL_FAST_BIT];
        end
        `OFS_MASK: begin
          mask_d = {regWrData[`FLAG_MATCH_BIT], regWrData[`FLAG_TOP_BIT]};
        end
        default: begin
          // other offsets store nothing here
        end
      endcase
    end
    // counter: software load first, else count on the timer tick while pwm is on
    cnt_d = cnt_q;
    if (cntWr) begin
      cnt_d = regWrData;
    end else if (step) begin
      cnt_d = stepCnt;
    end
    // compare: latched at top while pwm is on, so no odd-length pulse appears; loaded at once while pwm is off
    cmpAct_d = cmpAct_q;
    if (!pwmOn) begin
      cmpAct_d = cmpHold_d;
    end else if (step && atTop) begin
      cmpAct_d = cmpHold_q;
    end
  end
  // ========================================================================
  // event stage and sticky flags; a set beats a clear in the same cycle
  always_comb begin
    topEvt_d    = step && atTop;
    matchEvt_d  = arriveMatch;
    flagTop_d   = flagTop_q;
    flagMatch_d = flagMatch_q;
    if (wrFlags && regWrData[`FLAG_TOP_BIT]) begin
      flagTop_d = 1'b0;
    end
    if (wrFlags && regWrData[`FLAG_MATCH_BIT]) begin
      flagMatch_d = 1'b0;
    end
    if (topEvt_q) begin
      flagTop_d = 1'b1;
    end
    if (matchEvt_q) begin
      flagMatch_d = 1'b1;
    end
  end
  // interrupt requests need the flag, its enable and the global enable
  assign irqTop    = flagTop_q && mask_q[0] && globalIntEnable;
  assign irqMatchA = flagMatch_q && mask_q[1] && globalIntEnable;
  // ========================================================================
  // raw pwm signal a
  always_comb begin
    outA_d = outA_q;
    if (cmpAct_q == 8'h00) begin
      outA_d = (mode == timer1_pwm_pkg::OUT_SET);
    end else if (cmpAct_q == top_q) begin
      outA_d = (mode != timer1_pwm_pkg::OUT_SET);
    end else if (arriveMatch) begin
      outA_d = (mode == timer1_pwm_pkg::OUT_SET);
    end else if (step && stepCnt == 8'h01) begin
      outA_d = (mode == timer1_pwm_pkg::OUT_CLR);
    end
  end
  // codes 00 and 01 leave the pin undriven
  assign pwmOutAEn = pwmOn && mode[1];
  assign pwmOutBEn = ctrl_q[`CTRL_OEB_BIT];
  // ========================================================================
  // read path: data stand in the cycle after the strobe
  always_comb begin
    rdData_d = 8'h00;
    if (regRdStb) begin
      unique case (regAddr)
        `OFS_CTRL:        rdData_d = ctrl_q;
        `OFS_TOP:         rdData_d = top_q;
        `OFS_CMP_A:       rdData_d = cmpHold_q;
        `OFS_COUNT:       rdData_d = cnt_q;
        `OFS_DT_A:        rdData_d = dtA_q;
        `OFS_DT_B:        rdData_d = dtB_q;
        `OFS_DT_PRESCALE: rdData_d = {6'h00, dtPre_q};
        `OFS_PLL: begin
          rdData_d = {5'h00, fastEnEff, pllEnEff, lockSync_q};
        end
        `OFS_FLAGS: begin
          rdData_d = {1'b0, flagMatch_q, 3'h0, flagTop_q, 2'h0};
        end
        `OFS_MASK: begin
          rdData_d = {1'b0, mask_q[1], 3'h0, mask_q[0], 2'h0};
        end
        default:          rdData_d = 8'h00;
      endcase
    end
  end
  assign regRdData = rdData_q;
  // ========================================================================
  // state registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q      <= `RST_BYTE;
      top_q       <= `RST_TOP;
      cmpHold_q   <= `RST_BYTE;
      cmpAct_q    <= `RST_BYTE;
      cnt_q       <= `RST_BYTE;
      dtA_q       <= `RST_BYTE;
      dtB_q       <= `RST_BYTE;
      dtPre_q     <= `RST_DT_PRESCALE;
      pllEn_q     <= `RST_PLL_EN;
      fastEn_q    <= 1'b0;
      mask_q      <= 2'h0;
      flagTop_q   <= 1'b0;
      flagMatch_q <= 1'b0;
      topEvt_q    <= 1'b0;
      matchEvt_q  <= 1'b0;
      outA_q      <= 1'b0;
      dtCnt_q     <= 3'h0;
      rdData_q    <= `RST_BYTE;
    end else begin
      ctrl_q      <= ctrl_d;
      top_q       <= top_d;
      cmpHold_q   <= cmpHold_d;
      cmpAct_q    <= cmpAct_d;
      cnt_q       <= cnt_d;
      dtA_q       <= dtA_d;
      dtB_q       <= dtB_d;
      dtPre_q     <= dtPre_d;
      pllEn_q     <= pllEn_d;
      fastEn_q    <= fastEn_d;
      mask_q      <= mask_d;
      flagTop_q   <= flagTop_d;
      flagMatch_q <= flagMatch_d;
      topEvt_q    <= topEvt_d;
      matchEvt_q  <= matchEvt_d;
      outA_q      <= outA_d;
      dtCnt_q     <= dtCnt_d;
      rdData_q    <= rdData_d;
    end
  end
  // ========================================================================
  // dead-time pairs: high nibble true delay, low nibble inverted delay
  assign dtChanA.pwm       = outA_q;
  assign dtChanA.dtTick    = dtTick;
  assign dtChanA.trueDelay = dtA_q[`DT_TRUE_HI:`DT_TRUE_LO];
  assign dtChanA.invDelay  = dtA_q[`DT_INV_HI:`DT_INV_LO];
  assign dtChanB.pwm       = pwmSrcB;
  assign dtChanB.dtTick    = dtTick;
  assign dtChanB.trueDelay = dtB_q[`DT_TRUE_HI:`DT_TRUE_LO];
  assign dtChanB.invDelay  = dtB_q[`DT_INV_HI:`DT_INV_LO];
  // one generator per output, each with its own counter
  deadtime_gen #(.DT_W(4)) u_dt_a (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .dt      (dtChanA)
  );
  deadtime_gen #(.DT_W(4)) u_dt_b (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .dt      (dtChanB)
  );
  assign pwmOutA    = dtChanA.outTrue;
  assign pwmOutANeg = dtChanA.outInv;
  assign pwmOutB    = dtChanB.outTrue;
  assign pwmOutBNeg = dtChanB.outInv;
  // ========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_pll_reserved: assert property (
    (regRdStb && regAddr == `OFS_PLL) |=> (regRdData[7:3] == 5'h00))
    else $error("pll reserved bits not zero");
  a_pll_lock_read: assert property (
    (regRdStb && regAddr == `OFS_PLL) |=> (regRdData[0] == $past(lockSync_q)))
    else $error("lock bit does not follow pll lock");
  a_compat_force: assert property (
    compSync_q |-> (pllEnable && fastClockEnable))
    else $error("legacy mode did not force enables");
  a_count_step: assert property (
    (step && !atTop && !cntWr) |=> (cnt_q == 8'($past(cnt_q) + 8'h01)))
    else $error("counter did not step up");
  a_count_wrap: assert property (
    (step && atTop && !cntWr) |=> (cnt_q == 8'h00))
    else $error("counter did not restart after top");
  a_top_flag: assert property (
    (step && atTop) |-> ##`FLAG_DELAY flagTop_q)
    else $error("top flag not set after match");
  a_match_flag: assert property (
    arriveMatch |-> ##`FLAG_DELAY flagMatch_q)
    else $error("match flag not set after match");
  a_cmp_latch: assert property (
    (pwmOn && step && atTop) |=> (cmpAct_q == $past(cmpHold_q)))
    else $error("compare not latched at top");
  a_cmp_readback: assert property (
    (regWrStb && regAddr == `OFS_CMP_A) ##1 (regRdStb && regAddr == `OFS_CMP_A)
    |=> (regRdData == $past(regWrData, 2)))
    else $error("compare read missed latest write");
  a_static_zero: assert property (
    (cmpAct_q == 8'h00 && mode == timer1_pwm_pkg::OUT_SET) |=> outA_q)
    else $error("static output wrong for compare zero");
  a_irq_gate: assert property (
    irqTop |-> (flagTop_q && globalIntEnable))
    else $error("top interrupt without enables");
  a_dt_prescale: assert property (
    (dtTick && dtPre_q == 2'h3) |-> (dtCnt_q == 3'h7))
    else $error("dead-time prescale not by eight");
  c_top_event: cover property (step && atTop);
  c_match_event: cover property (arriveMatch && mode == timer1_pwm_pkg::OUT_CLR);
  c_flag_clear: cover property (wrFlags && flagTop_q);
  c_compat: cover property (compSync_q && !pllEn_q);
endmodule

//--- testbench/power_switch_model.sv
// model of the external power switch pair driven by one output pair
`timescale 1ns/1ps
module power_switch_model (
  input  wire logic       ref_clk,
  input  wire logic       hiOn,
  input  wire logic       loOn,
  output logic      [7:0] overlapCnt
);
  // ==========================================================================
  // shoot-through watch: both switches on together would short the rail
  initial overlapCnt = 8'h00;
  always @(posedge ref_clk) begin
    if (hiOn === 1'b1 && loOn === 1'b1) begin
      overlapCnt <= overlapCnt + 8'h01;
    end
  end
endmodule

//--- testbench/timer1_pwm_deadtime_bench.sv
// self-checking bench of the timer1 pwm block with dead-time pairs
`timescale 1ns/1ps
`include "timer1_pwm_params.svh"
module timer1_pwm_deadtime_bench;
  // ==========================================================================
  // stimulus and observed signals
  logic       ref_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic       wrStb   = 1'b0;
  logic       rdStb   = 1'b0;
  logic       lock    = 1'b0;
  logic       compat  = 1'b0;
  logic       srcB    = 1'b0;
  logic       gie     = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wrData  = 8'h00;
  logic [7:0] rdData, ovl;
  logic       outA, outANeg, outAEn, outB, outBNeg, outBEn;
  logic       pllEn, fastEn, irqT, irqM;
  int         errorCnt = 0, checkCount = 0, cyc = 0, n;
  // pwm table: mode, compare value, high cycles out of sixteen
  logic [1:0] md [5] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3};
  logic [7:0] cv [5] = '{8'h02, 8'h02, 8'h00, 8'h03, 8'h00};
  logic [7:0] ex [5] = '{8'h04, 8'h0c, 8'h00, 8'h10, 8'h10};
  // ==========================================================================
  // clock, and a hang guard far above the few hundred cycles needed
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      testDone();
    end
  end
  timer1_pwm_deadtime u_timer1_pwm_deadtime (
    .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(addr), .regWrData(wrData),
    .regWrStb(wrStb), .regRdStb(rdStb), .regRdData(rdData),
    .fastTick(1'b0), .pllLockedPin(lock), .compatModePin(compat),
    .globalIntEnable(gie), .pwmSrcB(srcB), .pllEnable(pllEn),
    .fastClockEnable(fastEn), .pwmOutA(outA), .pwmOutANeg(outANeg),
    .pwmOutAEn(outAEn), .pwmOutB(outB), .pwmOutBNeg(outBNeg),
    .pwmOutBEn(outBEn), .irqTop(irqT), .irqMatchA(irqM));
  power_switch_model u_power_switch_model (
    .ref_clk(ref_clk), .hiOn(outA), .loOn(outANeg), .overlapCnt(ovl));
  // ==========================================================================
  // compare, register port cycles and the closing report
  task chk(input timer1_pwm_pkg::byte_t got, input timer1_pwm_pkg::byte_t exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1 chk(rdData, exp);
  endtask
  // write then read with no idle cycle between the two strobes
  task wrRd(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1 chk(rdData, d);
  endtask
  // count high cycles of the true output over four whole periods
  task meas(input logic [7:0] exp);
    n = 0;
    repeat (16) begin
      @(posedge ref_clk);
      #1 if (outA === 1'b1) n++;
    end
    chk(n[7:0], exp);
  endtask
  task testDone();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`OFS_PLL, 8'h00);
    rd(`OFS_DT_B, 8'h00);
    rd(8'h3f, 8'h00);
    wr(`OFS_PLL, 8'hff);
    rd(`OFS_PLL, 8'h06);
    lock <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`OFS_PLL, 8'h07);
    wr(`OFS_PLL, 8'h00);
    compat <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`OFS_PLL, 8'h07);
    chk({6'h00, pllEn, fastEn}, 8'h03);
    $display("test pll done");
    wr(`OFS_TOP, 8'h03);
    wr(`OFS_CMP_A, 8'h02);
    rd(`OFS_CMP_A, 8'h02);
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_CTRL, {2'h2, md[i], 4'h5});
      wrRd(`OFS_CMP_A, cv[i]);
      repeat (12) @(posedge ref_clk);
      meas(ex[i]);
    end
    rd(`OFS_FLAGS, 8'h44);
    wr(`OFS_MASK, 8'h04);
    gie <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({6'h00, irqM, irqT}, 8'h01);
    $display("test pwm done");
    wr(`OFS_CTRL, 8'hf5);
    wr(`OFS_CMP_A, 8'h02);
    wr(`OFS_DT_A, 8'h20);
    repeat (12) @(posedge ref_clk);
    meas(8'h04);
    chk({6'h00, outAEn, outBEn}, 8'h03);
    chk(ovl, 8'h00);
    // pair b: two ticks of /8 keep both low well past five cycles
    wr(`OFS_DT_PRESCALE, 8'h03);
    wr(`OFS_DT_B, 8'h20);
    srcB <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1 chk({6'h00, outB, outBNeg}, 8'h00);
    repeat (15) @(posedge ref_clk);
    #1 chk({6'h00, outB, outBNeg}, 8'h02);
    $display("test dead time done");
    testDone();
  end
endmodule
